// ===== design/srh_pkg.sv
// srh_pkg: constants, register map and carrier types of the sort result handler block
// assumes one 20 MHz core clock and a synchronous active-high reset
// What this block does
// - comparator on: each measurement's sorting judgment appears on the handler lines
// - comparator off: sort lines idle; index and end lines stay low
// - alarm line follows the error state, whatever the comparator state
// - external trigger accepted only in external trigger mode
// - key-lock input low freezes the front-panel lock state
// - no error, primary in bin n, secondary in: bin n line, code n
// - primary out: no-class line plus low flag if below, else high flag; code 0
// - low cap adds its line to judgment, status 2; open: only it, code 11
// - every slash-named handler line is active low
// - low cap when primary value at or below percentage of range full scale
// - overload keeps every bin-class line high
package srh_pkg;

	// ----------------------------------------------------------------
	// register byte offsets
	// ----------------------------------------------------------------
	localparam logic [7:0] OFS_CTRL    = 8'h00;
	localparam logic [7:0] OFS_LIMIT   = 8'h04;
	localparam logic [7:0] OFS_RESULT  = 8'h08;
	localparam logic [7:0] OFS_VALUE   = 8'h0C;
	localparam logic [7:0] OFS_INT_ST  = 8'h10;
	localparam logic [7:0] OFS_INT_CLR = 8'h14;
	localparam logic [7:0] OFS_INT_EN  = 8'h18;
	localparam logic [7:0] OFS_LINES   = 8'h1C;

	// ----------------------------------------------------------------
	// field positions and codes
	// ----------------------------------------------------------------
	localparam int CTRL_W      = 5;
	localparam int LIMIT_W     = 17;
	localparam int RES_STAT_LSB = 8;
	localparam int INT_W       = 3;
	localparam int IRQ_DONE    = 0;
	localparam int IRQ_ERROR   = 1;
	localparam int IRQ_TRIG    = 2;
	localparam logic [3:0] CODE_NONE = 4'h0;
	localparam logic [3:0] CODE_AUX  = 4'hA;
	localparam logic [3:0] CODE_NOSORT = 4'hB;
	localparam logic [3:0] BIN_LAST  = 4'h9;
	localparam logic [1:0] ST_OK     = 2'h0;
	localparam logic [1:0] ST_OVERRANGE_N   = 2'h1;
	localparam logic [1:0] ST_LOWC   = 2'h2;
	// single-precision pattern of the unsortable sentinel value
	localparam logic [31:0] VALUE_SENTINEL = 32'h7E94F56F;
	// low cap limit counts 0.001 % steps of full scale
	localparam logic [63:0] LIMIT_SCALE = 64'h00000000000186A0;
	localparam logic [LIMIT_W-1:0] LIMIT_RST = 17'h00000;
	localparam logic [8:0] CLASS_IDLE = 9'h1FF;

	// ----------------------------------------------------------------
	// carrier types
	// ----------------------------------------------------------------
	typedef struct packed {
		logic lock_req;
		logic lowc_en;
		logic trig_ext;
		logic aux_en;
		logic comp_en;
	} srh_ctrl_t;

	typedef struct packed {
		logic [8:0] class_n;
		logic       no_class_n;
		logic       aux_n;
		logic       phi_n;
		logic       plo_n;
		logic       sec_n;
		logic       ovr_n;
		logic       lowc_n;
	} srh_lines_t;

	localparam srh_lines_t LINES_IDLE = 16'hFFFF;

	typedef struct packed {
		logic [3:0]  code;
		logic [1:0]  status;
		logic [31:0] value;
	} srh_report_t;

	typedef struct packed {
		srh_lines_t  lines;
		srh_report_t report;
	} srh_judge_t;

	typedef struct packed {
		srh_ctrl_t          ctrl;
		logic [LIMIT_W-1:0] limit;
		srh_lines_t         lines;
		srh_report_t        report;
		logic               index_n;
		logic               eom_n;
		logic               alarm_n;
		logic [2:0]         trig_s;
		logic [1:0]         key_s;
		logic               lock;
		logic               trig_pulse;
		logic [INT_W-1:0]   int_st;
		logic [INT_W-1:0]   int_en;
		logic               irq;
		logic               wr_pend;
		logic [7:0]         wr_addr;
		logic [31:0]        hrdata;
		logic               hreadyout;
	} srh_state_t;

endpackage

// ===== design/srh_top.sv
// srh_top: handler line encoder with AHB-Lite register slave and interrupt
// assumes the comparator supplies one done pulse per measurement on CORE_CLK;
// trigger and key-lock pins are asynchronous
`timescale 1ns/1ns
module srh_top (
	input  wire logic        CORE_CLK,
	input  wire logic        SRST,
	input  wire logic        HSEL,
	input  wire logic [31:0] HADDR,
	input  wire logic [1:0]  HTRANS,
	input  wire logic        HWRITE,
	input  wire logic [2:0]  HSIZE,
	input  wire logic [31:0] HWDATA,
	input  wire logic        HREADY,
	output logic      [31:0] HRDATA,
	output logic             HREADYOUT,
	output logic             HRESP,
	input  wire logic        MEAS_START,
	input  wire logic        MEAS_DONE,
	input  wire logic [3:0]  MEAS_BIN,
	input  wire logic        MEAS_BELOW,
	input  wire logic        MEAS_SEC_IN,
	input  wire logic        MEAS_OVERRANGE_N,
	input  wire logic        MEAS_OPEN,
	input  wire logic [31:0] MEAS_VALUE,
	input  wire logic [31:0] RANGE_FULL,
	input  wire logic        ERROR,
	input  wire logic        EXTERNAL_TRIGGER_IN,
	input  wire logic        KEY_LOCK_N,
	output logic      [8:0]  SORT_CLASS_N,
	output logic             NO_CLASS_N,
	output logic             AUXILIARY_CLASS_N,
	output logic             PRIMARY_HIGH_FAIL_N,
	output logic             PRIMARY_LOW_FAIL_N,
	output logic             SECONDARY_FAIL_N,
	output logic             OVERRANGE_N,
	output logic             LOW_CAP_OR_OPEN_N,
	output logic             INDEX_N,
	output logic             MEASURE_END_N,
	output logic             ALARM_N,
	output logic             TRIG_ACCEPT,
	output logic             PANEL_LOCK,
	output logic             IRQ
);

	localparam int INT_W_L = srh_pkg::INT_W;

	srh_pkg::srh_state_t s_q;
	srh_pkg::srh_state_t s_d;
	srh_pkg::srh_judge_t jdg;
	logic                addr_ok;
	logic [INT_W_L-1:0]  ev;

	// ----------------------------------------------------------------
	// judgment encoder
	// ----------------------------------------------------------------
	// low cap compare is done in 64 bits so no scaling precision is lost
	function automatic srh_pkg::srh_judge_t judge(
		input srh_pkg::srh_ctrl_t c,
		input logic [16:0]        lim,
		input logic [3:0]         bin,
		input logic               below,
		input logic               sec_in,
		input logic               overrange_n,
		input logic               open,
		input logic [31:0]        val,
		input logic [31:0]        fs
	);
		srh_pkg::srh_judge_t j;
		logic                lowc;
		j = '0;
		j.lines = srh_pkg::LINES_IDLE;
		j.report.value = val;
		j.report.status = srh_pkg::ST_OK;
		lowc = c.lowc_en && (({32'h0, val} * srh_pkg::LIMIT_SCALE) <=
			({32'h0, fs} * {47'h0, lim}));
		if (overrange_n) begin
			j.lines.ovr_n = 1'b0;
			j.report.status = srh_pkg::ST_OVERRANGE_N;
			j.report.value = srh_pkg::VALUE_SENTINEL;
			j.report.code = srh_pkg::CODE_NOSORT;
		end else if (open) begin
			j.lines.lowc_n = 1'b0;
			j.report.status = srh_pkg::ST_LOWC;
			j.report.value = srh_pkg::VALUE_SENTINEL;
			j.report.code = srh_pkg::CODE_NOSORT;
		end else begin
			if (bin != 4'h0 && bin <= srh_pkg::BIN_LAST) begin
				if (sec_in) begin
					j.lines.class_n[bin - 4'h1] = 1'b0;
					j.report.code = bin;
				end else begin
					j.lines.sec_n = 1'b0;
					if (c.aux_en) begin
						j.lines.aux_n = 1'b0;
						j.report.code = srh_pkg::CODE_AUX;
					end else begin
						j.lines.no_class_n = 1'b0;
						j.report.code = srh_pkg::CODE_NONE;
					end
				end
			end else begin
				j.lines.no_class_n = 1'b0;
				j.report.code = srh_pkg::CODE_NONE;
				if (below) begin
					j.lines.plo_n = 1'b0;
				end else begin
					j.lines.phi_n = 1'b0;
				end
			end
			if (lowc) begin
				j.lines.lowc_n = 1'b0;
				j.report.status = srh_pkg::ST_LOWC;
			end
		end
		return j;
	endfunction

	// ----------------------------------------------------------------
	// register read mux
	// ----------------------------------------------------------------
	function automatic logic [31:0] rd_mux(
		input srh_pkg::srh_state_t s,
		input logic [7:0]          a
	);
		logic [31:0] r;
		r = 32'h00000000;
		case (a)
			srh_pkg::OFS_CTRL:   r = {27'h0, s.ctrl};
			srh_pkg::OFS_LIMIT:  r = {15'h0, s.limit};
			srh_pkg::OFS_RESULT: r = {22'h0, s.report.status, 4'h0, s.report.code};
			srh_pkg::OFS_VALUE:  r = s.report.value;
			srh_pkg::OFS_INT_ST: r = {29'h0, s.int_st};
			srh_pkg::OFS_INT_EN: r = {29'h0, s.int_en};
			srh_pkg::OFS_LINES:  r = {13'h0, s.index_n, s.eom_n, s.alarm_n, s.lines};
			default:             r = 32'h00000000;
		endcase
		return r;
	endfunction

	assign jdg = judge(s_q.ctrl, s_q.limit, MEAS_BIN, MEAS_BELOW, MEAS_SEC_IN,
		MEAS_OVERRANGE_N, MEAS_OPEN, MEAS_VALUE, RANGE_FULL);
	assign addr_ok = HSEL && HTRANS[1] && HREADY;

	// ----------------------------------------------------------------
	// next state
	// ----------------------------------------------------------------
	always_comb begin
		s_d = s_q;
		ev = '0;
		s_d.hreadyout = 1'b1;
		// pin synchronisers: stage 0 feeds stage 1 only
		s_d.trig_s = {s_q.trig_s[1:0], EXTERNAL_TRIGGER_IN};
		s_d.key_s = {s_q.key_s[0], KEY_LOCK_N};
		s_d.trig_pulse = s_q.trig_s[1] && !s_q.trig_s[2] && s_q.ctrl.trig_ext;
		if (s_q.key_s[1]) begin
			s_d.lock = s_q.ctrl.lock_req;
		end
		s_d.alarm_n = !ERROR;
		if (MEAS_DONE) begin
			s_d.report = jdg.report;
		end
		if (!s_q.ctrl.comp_en) begin
			s_d.lines = srh_pkg::LINES_IDLE;
			s_d.index_n = 1'b0;
			s_d.eom_n = 1'b0;
		end else if (MEAS_DONE) begin
			s_d.lines = jdg.lines;
			s_d.index_n = 1'b0;
			s_d.eom_n = 1'b0;
		end else if (MEAS_START) begin
			s_d.index_n = 1'b1;
			s_d.eom_n = 1'b1;
		end
		// bus: read data registered in the address phase, write in the data phase
		s_d.wr_pend = addr_ok && HWRITE;
		if (addr_ok) begin
			s_d.wr_addr = HADDR[7:0];
			if (!HWRITE) begin
				s_d.hrdata = rd_mux(s_q, HADDR[7:0]);
			end
		end
		if (s_q.wr_pend) begin
			case (s_q.wr_addr)
				srh_pkg::OFS_CTRL:    s_d.ctrl = HWDATA[srh_pkg::CTRL_W-1:0];
				srh_pkg::OFS_LIMIT:   s_d.limit = HWDATA[srh_pkg::LIMIT_W-1:0];
				srh_pkg::OFS_INT_CLR: s_d.int_st = s_q.int_st & ~HWDATA[INT_W_L-1:0];
				srh_pkg::OFS_INT_EN:  s_d.int_en = HWDATA[INT_W_L-1:0];
				default:              s_d.int_en = s_q.int_en;
			endcase
		end
		ev[srh_pkg::IRQ_DONE] = MEAS_DONE;
		ev[srh_pkg::IRQ_ERROR] = ERROR;
		ev[srh_pkg::IRQ_TRIG] = s_d.trig_pulse;
		// a new event beats a clear in the same cycle
		s_d.int_st = s_d.int_st | ev;
		s_d.irq = |(s_d.int_st & s_d.int_en);
		if (SRST) begin
			s_d = '0;
			s_d.limit = srh_pkg::LIMIT_RST;
			s_d.lines = srh_pkg::LINES_IDLE;
			s_d.alarm_n = 1'b1;
			s_d.hreadyout = 1'b1;
		end
	end

	always_ff @(posedge CORE_CLK) begin
		s_q <= s_d;
	end

	// ----------------------------------------------------------------
	// outputs
	// ----------------------------------------------------------------
	assign HRDATA              = s_q.hrdata;
	assign HREADYOUT           = s_q.hreadyout;
	assign HRESP               = 1'b0 & s_q.hreadyout;
	assign SORT_CLASS_N        = s_q.lines.class_n;
	assign NO_CLASS_N          = s_q.lines.no_class_n;
	assign AUXILIARY_CLASS_N   = s_q.lines.aux_n;
	assign PRIMARY_HIGH_FAIL_N = s_q.lines.phi_n;
	assign PRIMARY_LOW_FAIL_N  = s_q.lines.plo_n;
	assign SECONDARY_FAIL_N    = s_q.lines.sec_n;
	assign OVERRANGE_N         = s_q.lines.ovr_n;
	assign LOW_CAP_OR_OPEN_N   = s_q.lines.lowc_n;
	assign INDEX_N             = s_q.index_n;
	assign MEASURE_END_N       = s_q.eom_n;
	assign ALARM_N             = s_q.alarm_n;
	assign TRIG_ACCEPT         = s_q.trig_pulse;
	assign PANEL_LOCK          = s_q.lock;
	assign IRQ                 = s_q.irq;

	// ----------------------------------------------------------------
	// assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge CORE_CLK); endclocking
	default disable iff (SRST);

	logic normal;
	assign normal = MEAS_DONE && s_q.ctrl.comp_en && !MEAS_OVERRANGE_N && !MEAS_OPEN;

	property p_bin_line;
		normal && MEAS_SEC_IN && MEAS_BIN != 4'h0 && MEAS_BIN <= 4'h9 |=>
			(~s_q.lines.class_n == (9'h001 << ($past(MEAS_BIN) - 4'h1)))
			&& s_q.report.code == $past(MEAS_BIN);
	endproperty
	a_bin_line: assert property (p_bin_line)
		else $error("bin line or code wrong");

	property p_comp_off;
		!s_q.ctrl.comp_en |=> s_q.lines == srh_pkg::LINES_IDLE && !INDEX_N && !MEASURE_END_N;
	endproperty
	a_comp_off: assert property (p_comp_off)
		else $error("lines active with comparator off");

	property p_alarm;
		1'b1 |=> ALARM_N == !$past(ERROR);
	endproperty
	a_alarm: assert property (p_alarm)
		else $error("alarm does not follow error");

	property p_trig;
		TRIG_ACCEPT |-> $past(s_q.ctrl.trig_ext) && $past(s_q.trig_s[1], 1)
			&& !$past(s_q.trig_s[2], 1);
	endproperty
	a_trig: assert property (p_trig)
		else $error("trigger accepted outside external mode");

	property p_lock;
		!s_q.key_s[1] |=> $stable(PANEL_LOCK);
	endproperty
	a_lock: assert property (p_lock)
		else $error("lock changed while key lock low");

	property p_out;
		normal && (MEAS_BIN == 4'h0 || MEAS_BIN > 4'h9) |=> !NO_CLASS_N
			&& (PRIMARY_LOW_FAIL_N == !$past(MEAS_BELOW))
			&& (PRIMARY_HIGH_FAIL_N == $past(MEAS_BELOW)) && s_q.report.code == 4'h0;
	endproperty
	a_out: assert property (p_out)
		else $error("primary out judgment wrong");

	property p_sec;
		normal && !MEAS_SEC_IN && MEAS_BIN != 4'h0 && MEAS_BIN <= 4'h9 |=> !SECONDARY_FAIL_N
			&& (AUXILIARY_CLASS_N == !$past(s_q.ctrl.aux_en)) && NO_CLASS_N == !AUXILIARY_CLASS_N
			&& s_q.report.code == ($past(s_q.ctrl.aux_en) ? 4'hA : 4'h0);
	endproperty
	a_sec: assert property (p_sec)
		else $error("secondary fail judgment wrong");

	property p_overrange_n;
		MEAS_DONE && s_q.ctrl.comp_en && MEAS_OVERRANGE_N |=> !OVERRANGE_N
			&& SORT_CLASS_N == 9'h1FF && NO_CLASS_N && AUXILIARY_CLASS_N
			&& s_q.report.code == 4'hB && s_q.report.status == 2'h1;
	endproperty
	a_overrange_n: assert property (p_overrange_n)
		else $error("overload output wrong");

	property p_open;
		MEAS_DONE && s_q.ctrl.comp_en && !MEAS_OVERRANGE_N && MEAS_OPEN |=> !LOW_CAP_OR_OPEN_N
			&& OVERRANGE_N && s_q.report.code == 4'hB && s_q.report.status == 2'h2;
	endproperty
	a_open: assert property (p_open)
		else $error("open contact output wrong");

	property p_onehot;
		1'b1 |-> $onehot0({~SORT_CLASS_N, ~NO_CLASS_N, ~AUXILIARY_CLASS_N});
	endproperty
	a_onehot: assert property (p_onehot)
		else $error("more than one class line low");

	property p_open_only;
		MEAS_DONE && s_q.ctrl.comp_en && !MEAS_OVERRANGE_N && MEAS_OPEN |=> SORT_CLASS_N == srh_pkg::CLASS_IDLE
			&& NO_CLASS_N && AUXILIARY_CLASS_N && PRIMARY_HIGH_FAIL_N && PRIMARY_LOW_FAIL_N
			&& SECONDARY_FAIL_N;
	endproperty
	a_open_only: assert property (p_open_only)
		else $error("open contact drives a sort line");

	property p_done_low;
		MEAS_DONE && s_q.ctrl.comp_en |=> !INDEX_N && !MEASURE_END_N;
	endproperty
	a_done_low: assert property (p_done_low)
		else $error("index or end line not low after done");

	property p_start_high;
		MEAS_START && !MEAS_DONE && s_q.ctrl.comp_en |=> INDEX_N && MEASURE_END_N;
	endproperty
	a_start_high: assert property (p_start_high)
		else $error("index or end line not released at start");

	// lines must stand between judgments so the handler can sample late
	property p_hold;
		s_q.ctrl.comp_en && !MEAS_DONE |=> $stable(s_q.lines);
	endproperty
	a_hold: assert property (p_hold)
		else $error("sort lines moved without a judgment");

	property p_lowc;
		normal && s_q.ctrl.lowc_en
			&& (({32'h0, MEAS_VALUE} * srh_pkg::LIMIT_SCALE)
			<= ({32'h0, RANGE_FULL} * {47'h0, s_q.limit}))
			|=> !LOW_CAP_OR_OPEN_N && s_q.report.status == srh_pkg::ST_LOWC;
	endproperty
	a_lowc: assert property (p_lowc)
		else $error("low cap not flagged at or below limit");

	// a clear written while the error still stands must not lose it
	property p_err_sticky;
		ERROR && s_q.wr_pend && s_q.wr_addr == srh_pkg::OFS_INT_CLR
			|=> s_q.int_st[srh_pkg::IRQ_ERROR];
	endproperty
	a_err_sticky: assert property (p_err_sticky)
		else $error("error status lost to a clear");

endmodule // srh_top

// ===== testbench/srh_handler_model.sv
// srh_handler_model: component handler on the far side of the sort lines
// assumes the lines come straight from the block's registered outputs
`timescale 1ns/1ns
module srh_handler_model (
	input  wire logic        clk,
	input  wire logic [15:0] lines_n,
	output logic             trig,
	output logic             key_lock_n,
	output logic [3:0]       bin_seen
);
	// ----------------------------------------------------------------
	// decode of the bin-class lines
	// ----------------------------------------------------------------
	// a low level means asserted on every slash-named line
	always_comb begin
		bin_seen = 4'h0;
		for (int i = 0; i < 9; i++) begin
			if (!lines_n[i+7]) bin_seen = 4'(i + 1);
		end
	end

	// ----------------------------------------------------------------
	// trigger and key-lock drive
	// ----------------------------------------------------------------
	// trigger rests low, as an unused pin tied to ground would
	initial begin
		trig = 1'b0;
		key_lock_n = 1'b1;
	end

	task automatic pulse_trig();
		@(posedge clk);
		trig <= 1'b1;
		repeat (3) @(posedge clk);
		trig <= 1'b0;
	endtask

	task automatic set_key(input logic v);
		@(posedge clk);
		key_lock_n <= v;
	endtask
endmodule // srh_handler_model

// ===== testbench/srh_top_tb.sv
// srh_top_tb: self-checking bench for the sort result handler block
// assumes the zero-wait AHB-Lite slave of the design and the handler model beside it
`timescale 1ns/1ns
module srh_top_tb;
	logic        clk, srst, hsel, hwrite, hreadyout, hresp, irq;
	logic [31:0] haddr, hwdata, hrdata, meas_value, range_full, q;
	logic [1:0]  htrans;
	logic        meas_start, meas_done, meas_below, meas_sec_in, meas_overrange_n, meas_open;
	logic [3:0]  meas_bin, bin_seen;
	logic        error, trig, key_n, trig_acc, panel_lock, index_n, eom_n, alarm_n;
	logic [8:0]  sort_class_n;
	logic        no_class_n, aux_n, phi_n, plo_n, sec_n, ovr_n, lowc_n;
	logic [15:0] lines_w;
	int          fails, num_checks, cycles, n;

	assign lines_w = {sort_class_n, no_class_n, aux_n, phi_n, plo_n, sec_n, ovr_n, lowc_n};

	srh_top u_dut (
		.CORE_CLK(clk), .SRST(srst), .HSEL(hsel), .HADDR(haddr), .HTRANS(htrans),
		.HWRITE(hwrite), .HSIZE(3'h2), .HWDATA(hwdata), .HREADY(hreadyout),
		.HRDATA(hrdata), .HREADYOUT(hreadyout), .HRESP(hresp), .MEAS_START(meas_start),
		.MEAS_DONE(meas_done), .MEAS_BIN(meas_bin), .MEAS_BELOW(meas_below),
		.MEAS_SEC_IN(meas_sec_in), .MEAS_OVERRANGE_N(meas_overrange_n), .MEAS_OPEN(meas_open),
		.MEAS_VALUE(meas_value), .RANGE_FULL(range_full), .ERROR(error),
		.EXTERNAL_TRIGGER_IN(trig), .KEY_LOCK_N(key_n), .SORT_CLASS_N(sort_class_n),
		.NO_CLASS_N(no_class_n), .AUXILIARY_CLASS_N(aux_n), .PRIMARY_HIGH_FAIL_N(phi_n),
		.PRIMARY_LOW_FAIL_N(plo_n), .SECONDARY_FAIL_N(sec_n), .OVERRANGE_N(ovr_n),
		.LOW_CAP_OR_OPEN_N(lowc_n), .INDEX_N(index_n), .MEASURE_END_N(eom_n),
		.ALARM_N(alarm_n), .TRIG_ACCEPT(trig_acc), .PANEL_LOCK(panel_lock), .IRQ(irq)
	);

	srh_handler_model u_hnd (
		.clk(clk), .lines_n(lines_w), .trig(trig), .key_lock_n(key_n), .bin_seen(bin_seen)
	);

	// ----------------------------------------------------------------
	// clock and timeout
	// ----------------------------------------------------------------
	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end

	// the whole run needs well under a thousand cycles
	always @(posedge clk) begin
		cycles++;
		if (cycles == 20000) begin
			fails++;
			summarize();
		end
	end

	// ----------------------------------------------------------------
	// shared tasks
	// ----------------------------------------------------------------
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			fails++;
			$display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask

	// one single transfer; waits on hready, no assumed latency
	task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		hsel <= 1'b1;
		htrans <= 2'h2;
		haddr <= 32'(a);
		hwrite <= wr;
		@(posedge clk);
		while (!hreadyout) @(posedge clk);
		htrans <= 2'h0;
		hsel <= 1'b0;
		hwdata <= d;
		@(posedge clk);
		while (!hreadyout) @(posedge clk);
		q = hrdata;
	endtask

	task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
		bus(1'b0, a, 32'h00000000);
		check(q, exp);
	endtask

	// f = {below, sec_in, overrange_n, open}; start pulse, then done one cycle later
	task automatic meas(input logic [3:0] b, input logic [3:0] f, input logic [31:0] v);
		@(posedge clk);
		meas_start <= 1'b1;
		@(posedge clk);
		meas_start <= 1'b0;
		meas_done <= 1'b1;
		meas_bin <= b;
		{meas_below, meas_sec_in, meas_overrange_n, meas_open} <= f;
		meas_value <= v;
		@(posedge clk);
		meas_done <= 1'b0;
		#1;
	endtask

	// m marks the lines expected low; result word carries code and status
	task automatic judge(input logic [3:0] b, input logic [3:0] f, input logic [31:0] v,
		input logic [15:0] m, input logic [3:0] code, input logic [1:0] st);
		meas(b, f, v);
		check(32'(lines_w), 32'(srh_pkg::LINES_IDLE & ~m));
		rd_chk(srh_pkg::OFS_RESULT, {22'h0, st, 4'h0, code});
	endtask

	task automatic count_acc(output int c);
		c = 0;
		repeat (8) begin
			@(posedge clk);
			#1;
			c += int'(trig_acc);
		end
	endtask

	task automatic summarize();
		$display("checks %0d, mismatches %0d", num_checks, fails);
		if (fails == 0 && num_checks > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask

	// ----------------------------------------------------------------
	// test sequence
	// ----------------------------------------------------------------
	initial begin
		{srst, hsel, hwrite, meas_start, meas_done, meas_below, meas_sec_in} = 7'h41;
		{meas_overrange_n, meas_open, error} = 3'h0;
		{haddr, hwdata, meas_value} = {32'h0, 32'h0, 32'h0};
		{htrans, meas_bin, range_full} = {2'h0, 4'h0, 32'h000F4240};
		repeat (4) @(posedge clk);
		srst <= 1'b0;
		rd_chk(srh_pkg::OFS_CTRL, 32'h00000000);
		check(32'({index_n, eom_n}), 32'h0);
		judge(4'h3, 4'h4, 32'h64, 16'h0000, 4'h3, srh_pkg::ST_OK);
		check(32'({index_n, eom_n}), 32'h0);
		bus(1'b1, srh_pkg::OFS_CTRL, 32'h00000001);
		for (n = 1; n <= 9; n++) begin
			judge(4'(n), 4'h4, 32'h64, 16'(1) << (n + 6), 4'(n), srh_pkg::ST_OK);
			check(32'(bin_seen), 32'(n));
		end
		check(32'({index_n, eom_n}), 32'h0);
		judge(4'h0, 4'hC, 32'h1, 16'h0048, srh_pkg::CODE_NONE, srh_pkg::ST_OK);
		judge(4'hC, 4'h4, 32'h1, 16'h0050, srh_pkg::CODE_NONE, srh_pkg::ST_OK);
		judge(4'h5, 4'h0, 32'h1, 16'h0044, srh_pkg::CODE_NONE, srh_pkg::ST_OK);
		bus(1'b1, srh_pkg::OFS_CTRL, 32'h00000003);
		judge(4'h5, 4'h0, 32'h1, 16'h0024, srh_pkg::CODE_AUX, srh_pkg::ST_OK);
		judge(4'h4, 4'h6, 32'h1, 16'h0002, srh_pkg::CODE_NOSORT, srh_pkg::ST_OVERRANGE_N);
		rd_chk(srh_pkg::OFS_VALUE, srh_pkg::VALUE_SENTINEL);
		judge(4'h4, 4'h5, 32'h1, 16'h0001, srh_pkg::CODE_NOSORT, srh_pkg::ST_LOWC);
		rd_chk(srh_pkg::OFS_VALUE, srh_pkg::VALUE_SENTINEL);
		// limit 1000 steps of 0.001 % is 1 % of full scale: 10000 sits on the boundary
		bus(1'b1, srh_pkg::OFS_LIMIT, 32'h000003E8);
		bus(1'b1, srh_pkg::OFS_CTRL, 32'h00000009);
		judge(4'h2, 4'h4, 32'h2710, 16'h0101, 4'h2, srh_pkg::ST_LOWC);
		rd_chk(srh_pkg::OFS_VALUE, 32'h00002710);
		judge(4'h2, 4'h4, 32'h2711, 16'h0100, 4'h2, srh_pkg::ST_OK);
		// low cap on, comparator off: lines idle, result still updates
		bus(1'b1, srh_pkg::OFS_CTRL, 32'h00000008);
		judge(4'h2, 4'h4, 32'h2710, 16'h0000, 4'h2, srh_pkg::ST_LOWC);
		bus(1'b1, srh_pkg::OFS_INT_EN, 32'h00000002);
		error <= 1'b1;
		repeat (3) @(posedge clk);
		#1;
		check(32'({alarm_n, irq}), 32'h1);
		bus(1'b1, srh_pkg::OFS_INT_CLR, 32'h00000002);
		rd_chk(srh_pkg::OFS_INT_ST, 32'h00000003);
		error <= 1'b0;
		bus(1'b1, srh_pkg::OFS_INT_CLR, 32'h00000002);
		repeat (3) @(posedge clk);
		#1;
		check(32'({alarm_n, irq}), 32'h2);
		fork
			u_hnd.pulse_trig();
			count_acc(n);
		join
		check(32'(n), 32'h0);
		bus(1'b1, srh_pkg::OFS_CTRL, 32'h00000004);
		fork
			u_hnd.pulse_trig();
			count_acc(n);
		join
		check(32'(n), 32'h1);
		rd_chk(srh_pkg::OFS_INT_ST, 32'h00000005);
		u_hnd.set_key(1'b0);
		bus(1'b1, srh_pkg::OFS_CTRL, 32'h00000010);
		repeat (4) @(posedge clk);
		#1;
		check(32'(panel_lock), 32'h0);
		u_hnd.set_key(1'b1);
		repeat (4) @(posedge clk);
		#1;
		check(32'(panel_lock), 32'h1);
		rd_chk(srh_pkg::OFS_LINES, 32'h0001FFFF);
		rd_chk(8'h40, 32'h00000000);
		summarize();
	end
endmodule // srh_top_tb
